// file: logic/bdbc_bridge_ctrl.sv
`timescale 1ns/100ps
module bdbc_bridge_ctrl #(
  parameter int IDLE_CYC  = bdbc_pkg::IDLE_CYC,
  parameter int RETRY_CYC = bdbc_pkg::RETRY_CYC,
  parameter bit RETRY_PIN = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic drive_in_a,
  input  wire logic drive_in_b,
  input  wire logic current_trip,
  input  wire logic zero_current,
  input  wire logic overcurrent_detect,
  input  wire logic retry_select,
  input  wire logic undervoltage_lockout,
  input  wire logic over_temp,
  output logic      bridge_out_a_src,
  output logic      bridge_out_a_snk,
  output logic      bridge_out_b_src,
  output logic      bridge_out_b_snk,
  output logic      fault_flag_low_o,
  output logic      fault_flag_low_oe,
  output logic      standby_o
);
  bdbc_pkg::bdbc_state_e        st_r;
  bdbc_pkg::bdbc_state_e        st_nxt;
  bdbc_pkg::bdbc_state_e        dec_st;
  logic [bdbc_pkg::CNT_W-1:0]   cnt_r;
  logic [bdbc_pkg::CNT_W-1:0]   cnt_nxt;
  logic                         dir_r;
  logic                         dir_nxt;
  logic                         zc_r;
  logic                         zc_nxt;
  logic                         standby_r;
  logic                         standby_nxt;
  logic                         fault_r;
  logic                         fault_nxt;
  logic                         flag_o_r;
  logic [3:0]                   gate_req;
  logic                         cmd_fwd;
  logic                         cmd_rev;
  logic                         cmd_brk;
  logic                         cmd_cst;
  logic                         same_dir;
  logic                         inhibit;
  logic                         stby_exit;
  logic                         retry_mode;
  logic                         idle_done;
  logic                         qual_done;
  logic                         retry_done;

  assign cmd_fwd    = drive_in_a & ~drive_in_b;
  assign cmd_rev    = ~drive_in_a & drive_in_b;
  assign cmd_brk    = drive_in_a & drive_in_b;
  assign cmd_cst    = ~drive_in_a & ~drive_in_b;
  assign same_dir   = dir_r ? cmd_fwd : cmd_rev;
  assign stby_exit  = standby_r & ~cmd_cst;
  assign retry_mode = RETRY_PIN & ~retry_select;
  assign inhibit    = fault_r | undervoltage_lockout | over_temp;

  // idle timer restarts whenever either input is high
  bdbc_timer #(
    .W     (bdbc_pkg::LONG_W),
    .LIMIT (IDLE_CYC)
  ) u_idle (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .run     (cmd_cst & ~standby_r),
    .done    (idle_done)
  );

  bdbc_timer #(
    .W     (bdbc_pkg::CNT_W),
    .LIMIT (int'(bdbc_pkg::QUAL_CYC))
  ) u_qual (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .run     (overcurrent_detect),
    .done    (qual_done)
  );

  bdbc_timer #(
    .W     (bdbc_pkg::LONG_W),
    .LIMIT (RETRY_CYC)
  ) u_retry (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .run     (fault_r & retry_mode & ~qual_done),
    .done    (retry_done)
  );

  // standby and fault flags
  always_comb begin
    standby_nxt = standby_r;
    if (!cmd_cst) begin
      standby_nxt = 1'b0;
    end else if (idle_done) begin
      standby_nxt = 1'b1;
    end
    fault_nxt = fault_r;
    if (qual_done) begin
      fault_nxt = 1'b1;
    end else if ((retry_mode & retry_done) | stby_exit) begin
      fault_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      standby_r <= 1'b0;
      fault_r   <= 1'b0;
      flag_o_r  <= 1'b0;
    end else begin
      standby_r <= standby_nxt;
      fault_r   <= fault_nxt;
      flag_o_r  <= 1'b0;
    end
  end

  // fresh decision from the command inputs
  always_comb begin
    if (cmd_fwd | cmd_rev) begin
      dec_st = bdbc_pkg::ST_ON;
    end else if (cmd_brk) begin
      dec_st = bdbc_pkg::ST_BRAKE;
    end else begin
      dec_st = bdbc_pkg::ST_IDLE;
    end
  end

  // chopper sequencer
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    zc_nxt  = zc_r;
    if (inhibit) begin
      st_nxt = bdbc_pkg::ST_OFF;
    end else if (standby_r) begin
      st_nxt = bdbc_pkg::ST_STBY;
    end else begin
      unique case (st_r)
        bdbc_pkg::ST_ON: begin
          if (!same_dir) begin
            st_nxt  = dec_st;
            cnt_nxt = '0;
            dir_nxt = cmd_fwd;
          end else if (cnt_r >= bdbc_pkg::BLANK_CYC && current_trip) begin
            st_nxt  = bdbc_pkg::ST_FAST;
            cnt_nxt = '0;
            zc_nxt  = 1'b0;
          end else if (cnt_r < bdbc_pkg::BLANK_CYC) begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        bdbc_pkg::ST_FAST, bdbc_pkg::ST_DEAD, bdbc_pkg::ST_SLOW: begin
          if (!same_dir) begin
            st_nxt  = dec_st;
            cnt_nxt = '0;
            dir_nxt = cmd_fwd;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
            if (zero_current) begin
              zc_nxt = 1'b1;
            end
            if (cnt_r == bdbc_pkg::HALF_CYC - 1'b1) begin
              st_nxt = bdbc_pkg::ST_DEAD;
            end else if (cnt_r == bdbc_pkg::HALF_CYC + bdbc_pkg::DEAD_CYC - 1'b1) begin
              st_nxt = bdbc_pkg::ST_SLOW;
            end else if (cnt_r == bdbc_pkg::OFF_CYC - 1'b1) begin
              st_nxt  = bdbc_pkg::ST_ON;
              cnt_nxt = '0;
              zc_nxt  = 1'b0;
            end
          end
        end
        bdbc_pkg::ST_IDLE, bdbc_pkg::ST_BRAKE, bdbc_pkg::ST_STBY, bdbc_pkg::ST_OFF: begin
          st_nxt  = dec_st;
          cnt_nxt = '0;
          dir_nxt = cmd_fwd;
          zc_nxt  = 1'b0;
        end
        default: begin
          st_nxt = bdbc_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r  <= bdbc_pkg::ST_IDLE;
      cnt_r <= '0;
      dir_r <= 1'b1;
      zc_r  <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      zc_r  <= zc_nxt;
    end
  end

  // gate pattern per sequencer state
  always_comb begin
    gate_req = bdbc_pkg::GATE_OFF;
    unique case (st_r)
      bdbc_pkg::ST_ON: begin
        gate_req = dir_r ? bdbc_pkg::GATE_AB : bdbc_pkg::GATE_BA;
      end
      bdbc_pkg::ST_FAST: begin
        if (!zc_r) begin
          gate_req = dir_r ? bdbc_pkg::GATE_BA : bdbc_pkg::GATE_AB;
        end
      end
      bdbc_pkg::ST_SLOW: begin
        if (!zc_r) begin
          gate_req = bdbc_pkg::GATE_LOWS;
        end
      end
      bdbc_pkg::ST_BRAKE: begin
        gate_req = bdbc_pkg::GATE_LOWS;
      end
      bdbc_pkg::ST_IDLE, bdbc_pkg::ST_DEAD, bdbc_pkg::ST_STBY, bdbc_pkg::ST_OFF: begin
        gate_req = bdbc_pkg::GATE_OFF;
      end
      default: begin
        gate_req = bdbc_pkg::GATE_OFF;
      end
    endcase
  end

  bdbc_gate_reg u_gate (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .gate_req (gate_req),
    .a_src_r  (bridge_out_a_src),
    .a_snk_r  (bridge_out_a_snk),
    .b_src_r  (bridge_out_b_src),
    .b_snk_r  (bridge_out_b_snk)
  );

  assign fault_flag_low_o  = flag_o_r;
  assign fault_flag_low_oe = fault_r;
  assign standby_o         = standby_r;

  logic [3:0] gates;
  assign gates = {bridge_out_a_src, bridge_out_a_snk, bridge_out_b_src, bridge_out_b_snk};

  AST_COAST_HIZ: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == bdbc_pkg::ST_IDLE |=> gates == 4'h0) else $error("coast not high impedance");
  AST_BRAKE_LOW: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == bdbc_pkg::ST_BRAKE |=> gates == 4'h5) else $error("brake not both low");
  AST_STBY_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    standby_r |=> ##1 gates == 4'h0) else $error("bridge on in standby");
  AST_STBY_ENTRY: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(standby_r) |-> $past(cmd_cst) && $past(idle_done)) else $error("early standby");
  AST_TRIP_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == bdbc_pkg::ST_ON && same_dir && !inhibit && !standby_r && current_trip
    && cnt_r >= bdbc_pkg::BLANK_CYC |=> st_r == bdbc_pkg::ST_FAST) else $error("trip missed");
  AST_BLANK: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == bdbc_pkg::ST_ON && cnt_r < bdbc_pkg::BLANK_CYC |=> st_r != bdbc_pkg::ST_FAST)
    else $error("trip taken in blanking");
  AST_FAST_HALF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == bdbc_pkg::ST_FAST && cnt_r == bdbc_pkg::HALF_CYC - 1'b1 && same_dir && !inhibit
    && !standby_r |=> st_r == bdbc_pkg::ST_DEAD) else $error("fast decay length wrong");
  AST_DEAD_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == bdbc_pkg::ST_DEAD |=> gates == 4'h0) else $error("drivers on in dead time");
  AST_OFF_END: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == bdbc_pkg::ST_SLOW && cnt_r == bdbc_pkg::OFF_CYC - 1'b1 && same_dir && !inhibit
    && !standby_r |=> st_r == bdbc_pkg::ST_ON ##1 gates != 4'h0) else $error("off-time wrong");
  AST_UNDERVOLT_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    undervoltage_lockout |-> ##2 gates == 4'h0) else $error("bridge on under undervoltage");
  AST_TEMP_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    over_temp |-> ##2 gates == 4'h0) else $error("bridge on when hot");
  // both ends of the 125-cycle qualification window must have seen the detector high
  AST_QUAL: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(fault_r) |-> $past(overcurrent_detect, 2) && $past(overcurrent_detect, 126))
    else $error("fault not qualified");
  AST_LATCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fault_r && !retry_mode && !stby_exit |=> fault_r) else $error("latch lost");

  COV_TRIP: cover property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == bdbc_pkg::ST_ON ##1 st_r == bdbc_pkg::ST_FAST);
  COV_STBY: cover property (@(posedge ref_clk) disable iff (!arst_n) $rose(standby_r));
  COV_RETRY: cover property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(fault_r) && retry_mode);
endmodule : bdbc_bridge_ctrl

// file: logic/bdbc_pkg.sv
// Notes on behaviour
// - a high, b low drives forward; a low, b high drives reverse.
// - forward trip: out_a held low, out_b chopped in mixed decay.
// - reverse trip: out_a chopped in mixed decay, out_b held low.
// - both inputs high: both outputs low, slow-decay brake.
// - both inputs low: both outputs high impedance, coast.
// - standby after both inputs low over 1 ms; any high restarts timer.
// - standby shuts down charge pump and regulator, bridge kept off.
// - each on-period enables one diagonal source/sink pair.
// - current trip ends the on-period and starts a mixed-decay off-period.
// - off-period lasts fixed 25 us, then drive re-enables.
// - trip is ten times sense voltage above reference, from comparator.
// - overcurrent flagged only after persisting the qualification time.
// - output short pulls open-drain fault flag low while fault active.
// - retry grounded: outputs off, re-enabled after 2 ms timeout.
// - retry open: overcurrent fault latched, outputs kept off.
// - latch clears only on standby exit or power cycle.
// - variant without retry input always latches overcurrent faults.
// - undervoltage indication keeps all bridge outputs off.
// - over-temperature indication disables bridge until it clears.
// - off-period is fast decay for half, then slow decay.
// - drivers all off for crossover dead time between fast and slow.
// - synchronous rectification during decay, off at zero current.
package bdbc_pkg;
  localparam int CLK_MHZ    = 125;
  localparam int IDLE_US    = 1000;
  localparam int RETRY_US   = 2000;
  localparam int WAKE_US    = 30;
  localparam int OFF_NS     = 25000;
  localparam int BLANK_NS   = 3000;
  localparam int QUAL_NS    = 1000;
  localparam int DEAD_NS    = 400;
  localparam int CNT_W      = 12;
  localparam int LONG_W     = 18;
  localparam int IDLE_CYC   = IDLE_US * CLK_MHZ;
  localparam int RETRY_CYC  = RETRY_US * CLK_MHZ;
  localparam int WAKE_CYC   = WAKE_US * CLK_MHZ;
  localparam logic [CNT_W-1:0] OFF_CYC   = CNT_W'(OFF_NS * CLK_MHZ / 1000);
  localparam logic [CNT_W-1:0] HALF_CYC  = CNT_W'(OFF_NS * CLK_MHZ / 2000);
  localparam logic [CNT_W-1:0] BLANK_CYC = CNT_W'(BLANK_NS * CLK_MHZ / 1000);
  localparam logic [CNT_W-1:0] QUAL_CYC  = CNT_W'((QUAL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] DEAD_CYC  = CNT_W'((DEAD_NS * CLK_MHZ + 999) / 1000);
  // gate request order {a_src, a_snk, b_src, b_snk}
  localparam logic [3:0] GATE_OFF   = 4'h0;
  localparam logic [3:0] GATE_AB    = 4'h9;
  localparam logic [3:0] GATE_BA    = 4'h6;
  localparam logic [3:0] GATE_LOWS  = 4'h5;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ON    = 8'h02,
    ST_FAST  = 8'h04,
    ST_DEAD  = 8'h08,
    ST_SLOW  = 8'h10,
    ST_BRAKE = 8'h20,
    ST_STBY  = 8'h40,
    ST_OFF   = 8'h80
  } bdbc_state_e;
endpackage : bdbc_pkg

// file: logic/bdbc_timer.sv
`timescale 1ns/100ps
module bdbc_timer #(
  parameter int W     = 18,
  parameter int LIMIT = 1000
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic run,
  output logic      done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r < W'(LIMIT)) begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (cnt_r == W'(LIMIT));
endmodule : bdbc_timer

// file: logic/bdbc_gate_reg.sv
`timescale 1ns/100ps
module bdbc_gate_reg (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] gate_req,
  output logic            a_src_r,
  output logic            a_snk_r,
  output logic            b_src_r,
  output logic            b_snk_r
);
  logic a_src_nxt;
  logic a_snk_nxt;
  logic b_src_nxt;
  logic b_snk_nxt;

  // a leg never gets source and sink together
  always_comb begin
    a_src_nxt = gate_req[3] & ~gate_req[2];
    a_snk_nxt = gate_req[2] & ~gate_req[3];
    b_src_nxt = gate_req[1] & ~gate_req[0];
    b_snk_nxt = gate_req[0] & ~gate_req[1];
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      a_src_r <= 1'b0;
      a_snk_r <= 1'b0;
      b_src_r <= 1'b0;
      b_snk_r <= 1'b0;
    end else begin
      a_src_r <= a_src_nxt;
      a_snk_r <= a_snk_nxt;
      b_src_r <= b_src_nxt;
      b_snk_r <= b_snk_nxt;
    end
  end
endmodule : bdbc_gate_reg

// file: testbench/bdbc_host_model.sv
`timescale 1ns/100ps
module bdbc_host_model #(
  parameter int WAKE = bdbc_pkg::WAKE_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] cmd,
  input  wire logic       standby_o,
  output logic            drive_in_a,
  output logic            drive_in_b
);
  int wait_r;
  // a one-cycle wake pulse, then inputs held low while the charge pump settles
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {drive_in_a, drive_in_b} <= 2'h0;
      wait_r                   <= 0;
    end else if (wait_r != 0) begin
      {drive_in_a, drive_in_b} <= 2'h0;
      wait_r                   <= wait_r - 1;
    end else if (standby_o && cmd != 2'h0) begin
      {drive_in_a, drive_in_b} <= 2'h2;
      wait_r                   <= WAKE;
    end else begin
      {drive_in_a, drive_in_b} <= cmd;
    end
  end
endmodule : bdbc_host_model

// file: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam int IDLE_C  = 4000;
  localparam int RETRY_C = 300;
  localparam int WAKE    = bdbc_pkg::WAKE_CYC;
  logic       ref_clk     = 1'b0;
  logic       arst_n      = 1'b0;
  logic [1:0] cmd         = 2'h0;
  logic       trip        = 1'b0;
  logic       zc          = 1'b0;
  logic       od          = 1'b0;
  logic       rsel        = 1'b0;
  logic       uv          = 1'b0;
  logic       ot          = 1'b0;
  wire        drive_in_a, drive_in_b, fl_o, fl_oe, sb, oe2;
  wire  [3:0] g, g2;
  int         miscompares = 0;
  int         n_compared  = 0;
  int         cycles      = 0;

  always #4 ref_clk = ~ref_clk;

  bdbc_host_model host (.ref_clk, .arst_n, .cmd, .standby_o(sb), .drive_in_a, .drive_in_b);
  bdbc_bridge_ctrl #(.IDLE_CYC(IDLE_C), .RETRY_CYC(RETRY_C)) uut (
    .ref_clk, .arst_n, .drive_in_a, .drive_in_b, .current_trip(trip), .zero_current(zc),
    .overcurrent_detect(od), .retry_select(rsel), .undervoltage_lockout(uv),
    .over_temp(ot), .bridge_out_a_src(g[3]), .bridge_out_a_snk(g[2]),
    .bridge_out_b_src(g[1]), .bridge_out_b_snk(g[0]), .fault_flag_low_o(fl_o),
    .fault_flag_low_oe(fl_oe), .standby_o(sb));
  // variant without a retry input sees the same stimulus
  bdbc_bridge_ctrl #(.IDLE_CYC(IDLE_C), .RETRY_CYC(RETRY_C), .RETRY_PIN(1'b0)) uut2 (
    .ref_clk, .arst_n, .drive_in_a, .drive_in_b, .current_trip(trip), .zero_current(zc),
    .overcurrent_detect(od), .retry_select(rsel), .undervoltage_lockout(uv),
    .over_temp(ot), .bridge_out_a_src(g2[3]), .bridge_out_a_snk(g2[2]),
    .bridge_out_b_src(g2[1]), .bridge_out_b_snk(g2[0]), .fault_flag_low_o(),
    .fault_flag_low_oe(oe2), .standby_o());

  function automatic logic [3:0] exp_gates(input logic [1:0] c, input logic off);
    if (off) return 4'h0;
    case (c)
      2'h2:    return 4'h9;
      2'h1:    return 4'h6;
      2'h3:    return 4'h5;
      default: return 4'h0;
    endcase
  endfunction : exp_gates

  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic fail(input string m);
    miscompares++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail

  task automatic chk_g(input logic [3:0] e);
    n_compared++;
    if (g !== e) fail("bridge gates");
  endtask : chk_g

  task automatic chk_b(input logic got, input logic e);
    n_compared++;
    if (got !== e) fail("flag level");
  endtask : chk_b

  task automatic chk_n(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) fail("cycle count");
  endtask : chk_n

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic wait_g(input logic [3:0] v, input int lim, output int n);
    n = 0;
    while (g !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_g

  // one trip-driven chop cycle: blanking, fast, dead, slow, sync-rect stop
  task automatic chop(input logic [1:0] c, input logic [3:0] on_v, input logic [3:0] fast_v);
    int n1, n2, n3, n4;
    cmd  <= 2'h0;
    cyc(4);
    cmd  <= c;
    trip <= 1'b1;
    wait_g(on_v, 10, n1);
    chk_n(n1, 3, 5);
    wait_g(fast_v, 500, n1);
    chk_n(n1, 367, 383);
    trip <= 1'b0;
    wait_g(4'h0, 2000, n1);
    chk_n(n1, 1558, 1566);
    wait_g(4'h5, 100, n2);
    chk_n(n2, 48, 52);
    zc <= 1'b1;
    wait_g(4'h0, 6, n3);
    chk_n(n3, 1, 4);
    wait_g(on_v, 2000, n4);
    chk_n(n1 + n2 + n3 + n4, 3118, 3132);
    zc <= 1'b0;
  endtask : chop

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail("timeout");
      tally_and_finish();
    end
  end

  initial begin
    int n;
    logic [1:0] c;
    logic u, o;
    void'($urandom(32'h0638));
    cyc(2);
    chk_g(4'h0);
    chk_b(sb, 1'b0);
    cyc(8);
    arst_n <= 1'b1;
    for (int i = 0; i < 150; i++) begin
      c = 2'($urandom % 4);
      u = ($urandom % 5) == 0;
      o = ($urandom % 5) == 0;
      cmd  <= c;
      uv   <= u;
      ot   <= o;
      cyc(4);
      chk_g(exp_gates(c, u | o));
    end
    uv   <= 1'b0;
    ot   <= 1'b0;
    chop(2'h2, 4'h9, 4'h6);
    chop(2'h1, 4'h6, 4'h9);
    cmd <= 2'h2;
    cyc(5);
    od <= 1'b1;
    cyc(110);
    od <= 1'b0;
    cyc(5);
    chk_b(fl_oe, 1'b0);
    od <= 1'b1;
    cyc(140);
    od <= 1'b0;
    cyc(2);
    chk_b(fl_oe, 1'b1);
    chk_b(fl_o, 1'b0);
    chk_g(4'h0);
    wait_g(4'h9, 600, n);
    chk_n(n, RETRY_C - 10, RETRY_C + 10);
    chk_b(fl_oe, 1'b0);
    chk_b(oe2, 1'b1);
    chk_b(g2 == 4'h0, 1'b1);
    rsel <= 1'b1;
    od   <= 1'b1;
    cyc(140);
    od <= 1'b0;
    cyc(600);
    chk_g(4'h0);
    chk_b(fl_oe, 1'b1);
    cmd <= 2'h1;
    cyc(10);
    chk_g(4'h0);
    chk_b(fl_oe, 1'b1);
    cmd <= 2'h0;
    cyc(IDLE_C - 100);
    cmd <= 2'h3;
    cyc(1);
    cmd <= 2'h0;
    cyc(IDLE_C - 10);
    chk_b(sb, 1'b0);
    cyc(20);
    chk_b(sb, 1'b1);
    chk_g(4'h0);
    cmd <= 2'h2;
    cyc(WAKE - 20);
    chk_b(sb, 1'b0);
    chk_g(4'h0);
    wait_g(4'h9, 60, n);
    chk_n(n, 18, 32);
    chk_b(fl_oe, 1'b0);
    chk_b(oe2, 1'b0);
    chk_b(g2 == 4'h9, 1'b1);
    tally_and_finish();
  end
endmodule : tb_top
